// File: hdl/pkt_dma_regs.vh
/*
  Register offsets, field positions, reset values and interrupt bits
  of the packet DMA channel state block.
  Assumes byte addresses on an 8-bit register port, one word each.
*/
`ifndef PKT_DMA_REGS_VH
`define PKT_DMA_REGS_VH

// Register byte offsets
`define OFS_TX_STATE_FOUR   8'h00
`define OFS_TX_STATE_FIVE   8'h04
`define OFS_TX_DONE_PTR     8'h08
`define OFS_RX_STATE_ZERO   8'h0C
`define OFS_IRQ_STATUS      8'h10
`define OFS_IRQ_CLEAR       8'h14
`define OFS_IRQ_ENABLE      8'h18

// State word four fields
`define F_TAG_HI            31
`define F_TAG_LO            24
`define F_BUF_LAST          17
`define F_BUF_FIRST         16
`define F_BUF_LEFT_HI       15
`define F_BUF_LEFT_LO       0

// State word five fields
`define F_CUT_HI            31
`define F_CUT_LO            16
`define F_PKT_LEN_HI        15
`define F_PKT_LEN_LO        0

// Completion pointer fields
`define F_PTR_HI            31
`define F_PTR_LO            2
`define F_UPD_SEL           0

// Receive state word zero
`define F_SKIP_HI           7
`define F_SKIP_LO           0

// Interrupt status bits
`define IRQ_EOP_DONE        0
`define IRQ_CUT             1
`define IRQ_BUF_EMPTY       2
`define IRQ_BITS            3

// Reset values
`define RST_WORD            32'h0000_0000
`define RST_PTR             30'h0000_0000
`define RST_LEN             16'h0000
`define RST_TAG             8'h00
`define RST_SKIP            8'h00
`define RST_IRQ             3'h0

`endif

// File: hdl/byte_down_counter.v
/*
  Loadable down counter that drops by a variable amount and saturates
  at zero, flagging the step that empties it.
  Assumes load and decrement come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_down_counter #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         i_mclk,
  input  wire         i_rst,
  // Control
  input  wire         i_load,
  input  wire [W-1:0] i_load_val,
  input  wire         i_dec,
  input  wire [W-1:0] i_dec_amt,
  // State
  output reg  [W-1:0] o_count,
  output reg          o_emptied
);

  wire at_zero;
  wire runs_out;

  assign at_zero  = (o_count == {W{1'b0}});
  assign runs_out = i_dec && !at_zero && (o_count <= i_dec_amt);

  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_count   <= {W{1'b0}};
      o_emptied <= 1'b0;
    end else begin
      o_emptied <= runs_out && !i_load;
      // A fresh load overrides a decrement in the same cycle
      if (i_load) begin
        o_count <= i_load_val;
      end else if (runs_out) begin
        o_count <= {W{1'b0}};
      end else if (i_dec && !at_zero) begin
        o_count <= o_count - i_dec_amt;
      end
    end
  end

endmodule

`default_nettype wire

// File: hdl/pkt_dma_chan_state.v
/*
  Per-channel state of a descriptor packet DMA: transmit buffer flags
  and counts, remaining length before cut, packet tag, completion
  pointer with its queue interrupt, and receive first-buffer skip.
  Assumes a fetch engine on the same clock supplies descriptor fields
  and transfer sizes, and software uses the plain register port.
  Reserved bits and the write-only clear register read as zero.
  Counters saturate at zero: an oversized transfer empties them
  rather than wrapping round.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pkt_dma_regs.vh"

module pkt_dma_chan_state #(
  parameter AW = 8,
  parameter LW = 16
) (
  // Clock and reset
  input  wire          i_mclk,
  input  wire          i_rst,
  // Register port
  input  wire [AW-1:0] i_addr,
  input  wire [31:0]   i_wdata,
  input  wire          i_wr,
  input  wire          i_rd,
  output reg  [31:0]   o_rdata,
  // Transmit first descriptor fields
  input  wire          i_sop_load,
  input  wire [7:0]    i_sop_tag,
  input  wire [LW-1:0] i_sop_pkt_len,
  // Transmit buffer descriptor fields
  input  wire          i_buf_load,
  input  wire [LW-1:0] i_buf_len,
  input  wire          i_buf_first,
  input  wire          i_buf_last,
  // Transmit data movement
  input  wire          i_xfer,
  input  wire [LW-1:0] i_xfer_bytes,
  // End of packet processing
  input  wire          i_eop_done,
  input  wire [29:0]   i_eop_done_desc_ptr,
  // Receive data
  input  wire          i_rx_sop_start,
  input  wire          i_rx_byte,
  input  wire [7:0]    i_rx_data,
  // Transmit results
  output reg           o_next_desc,
  output reg           o_pkt_cut,
  output reg  [LW-1:0] o_trailer_len,
  output reg  [7:0]    o_rx_tag,
  // Receive results
  output reg           o_rx_store,
  output reg  [7:0]    o_rx_store_data,
  // Interrupts
  output reg           o_txq_irq,
  output reg           o_irq
);

  // Register decode
  wire wr_four;
  wire wr_five;
  wire wr_ptr;
  wire wr_skip;
  wire wr_clr;
  wire wr_en;

  assign wr_four = i_wr && (i_addr == `OFS_TX_STATE_FOUR);
  assign wr_five = i_wr && (i_addr == `OFS_TX_STATE_FIVE);
  assign wr_ptr  = i_wr && (i_addr == `OFS_TX_DONE_PTR);
  assign wr_skip = i_wr && (i_addr == `OFS_RX_STATE_ZERO);
  assign wr_clr  = i_wr && (i_addr == `OFS_IRQ_CLEAR);
  assign wr_en   = i_wr && (i_addr == `OFS_IRQ_ENABLE);

  // Stored state
  reg  [7:0]           packet_tag_byte;
  reg                  buf_is_last;
  reg                  buf_is_first;
  reg  [LW-1:0]        pkt_len;
  reg  [29:0]          done_desc_ptr;
  reg  [7:0]           first_buf_skip;
  reg  [`IRQ_BITS-1:0] irq_status;
  reg  [`IRQ_BITS-1:0] irq_enable;

  // Counter outputs
  wire [LW-1:0]        buf_bytes_left;
  wire                 buf_emptied;
  wire [LW-1:0]        bytes_until_cut;
  wire                 cut_reached;
  wire [7:0]           skip_left;

  // Hardware loads win over software writes in the same cycle
  wire                 buf_cnt_load;
  wire [LW-1:0]        buf_cnt_val;
  wire                 cut_cnt_load;
  wire [LW-1:0]        cut_cnt_val;

  assign buf_cnt_load = i_buf_load || wr_four;
  assign buf_cnt_val  = i_buf_load ? i_buf_len
                                   : i_wdata[`F_BUF_LEFT_HI:`F_BUF_LEFT_LO];
  assign cut_cnt_load = i_sop_load || wr_five;
  assign cut_cnt_val  = i_sop_load ? i_sop_pkt_len
                                   : i_wdata[`F_CUT_HI:`F_CUT_LO];

  // A byte arriving with the first-buffer strobe is that buffer's first
  // byte: it uses up one step of the skip, or is kept when the offset
  // is zero, so the buffer start never loses a byte
  wire                 skip_none;
  wire [7:0]           skip_load_val;
  wire                 rx_keep;

  assign skip_none     = (first_buf_skip == 8'h00);
  assign skip_load_val = (i_rx_byte && !skip_none) ? (first_buf_skip - 8'h01)
                                                   : first_buf_skip;
  assign rx_keep       = i_rx_sop_start ? skip_none : (skip_left == 8'h00);

  // Bytes left in current transmit buffer
  byte_down_counter #(
    .W          (LW)
  ) u_buf_cnt (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_load     (buf_cnt_load),
    .i_load_val (buf_cnt_val),
    .i_dec      (i_xfer),
    .i_dec_amt  (i_xfer_bytes),
    .o_count    (buf_bytes_left),
    .o_emptied  (buf_emptied)
  );

  // Bytes allowed before the packet is cut
  byte_down_counter #(
    .W          (LW)
  ) u_cut_cnt (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_load     (cut_cnt_load),
    .i_load_val (cut_cnt_val),
    .i_dec      (i_xfer),
    .i_dec_amt  (i_xfer_bytes),
    .o_count    (bytes_until_cut),
    .o_emptied  (cut_reached)
  );

  // Receive skip: one byte per step, reloaded at every first buffer
  byte_down_counter #(
    .W          (8)
  ) u_skip_cnt (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_load     (i_rx_sop_start),
    .i_load_val (skip_load_val),
    .i_dec      (i_rx_byte),
    .i_dec_amt  (8'h01),
    .o_count    (skip_left),
    .o_emptied  ()
  );

  // Tag, flags and packet length
  always @(posedge i_mclk) begin
    if (i_rst) begin
      packet_tag_byte <= `RST_TAG;
      buf_is_last     <= 1'b0;
      buf_is_first    <= 1'b0;
      pkt_len         <= `RST_LEN;
    end else begin
      if (i_sop_load) begin
        packet_tag_byte <= i_sop_tag;
        pkt_len         <= i_sop_pkt_len;
      end else begin
        if (wr_four) begin
          packet_tag_byte <= i_wdata[`F_TAG_HI:`F_TAG_LO];
        end
        if (wr_five) begin
          pkt_len <= i_wdata[`F_PKT_LEN_HI:`F_PKT_LEN_LO];
        end
      end
      if (i_buf_load) begin
        buf_is_last  <= i_buf_last;
        buf_is_first <= i_buf_first;
      end else if (wr_four) begin
        buf_is_last  <= i_wdata[`F_BUF_LAST];
        buf_is_first <= i_wdata[`F_BUF_FIRST];
      end
    end
  end

  // Completion pointer and queue interrupt
  wire ptr_match;
  wire txq_set;
  wire txq_clr;

  // A compare against a stale address leaves the interrupt up
  assign ptr_match = (i_wdata[`F_PTR_HI:`F_PTR_LO] == done_desc_ptr);
  assign txq_set   = i_eop_done || (wr_ptr && i_wdata[`F_UPD_SEL]);
  assign txq_clr   = wr_ptr && !i_wdata[`F_UPD_SEL] && ptr_match;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      done_desc_ptr <= `RST_PTR;
      o_txq_irq     <= 1'b0;
    end else begin
      // Engine's own update beats a software writeback in the same cycle
      if (i_eop_done) begin
        done_desc_ptr <= i_eop_done_desc_ptr;
      end else if (wr_ptr && i_wdata[`F_UPD_SEL]) begin
        done_desc_ptr <= i_wdata[`F_PTR_HI:`F_PTR_LO];
      end
      // Set wins so a completion racing the acknowledge is not lost
      if (txq_set) begin
        o_txq_irq <= 1'b1;
      end else if (txq_clr) begin
        o_txq_irq <= 1'b0;
      end
    end
  end

  // Receive skip offset, set up by software before the channel runs
  always @(posedge i_mclk) begin
    if (i_rst) begin
      first_buf_skip <= `RST_SKIP;
    end else if (wr_skip) begin
      first_buf_skip <= i_wdata[`F_SKIP_HI:`F_SKIP_LO];
    end
  end

  // Receive bytes pass only after the skip has run out
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_rx_store      <= 1'b0;
      o_rx_store_data <= 8'h00;
    end else begin
      o_rx_store      <= i_rx_byte && rx_keep;
      o_rx_store_data <= i_rx_data;
    end
  end

  // Transmit result strobes and held values
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_next_desc   <= 1'b0;
      o_pkt_cut     <= 1'b0;
      o_trailer_len <= `RST_LEN;
      o_rx_tag      <= `RST_TAG;
    end else begin
      o_next_desc   <= buf_emptied;
      o_pkt_cut     <= cut_reached;
      o_trailer_len <= pkt_len;
      o_rx_tag      <= packet_tag_byte;
    end
  end

  // Sticky event status, enable and the shared interrupt line
  wire [`IRQ_BITS-1:0] irq_events;
  wire [`IRQ_BITS-1:0] next_status;
  wire [`IRQ_BITS-1:0] next_enable;

  assign irq_events  = {buf_emptied, cut_reached, i_eop_done};
  assign next_status = (irq_status & ~(wr_clr ? i_wdata[`IRQ_BITS-1:0]
                                              : `RST_IRQ)) | irq_events;
  // An enable written this cycle counts at once
  assign next_enable = wr_en ? i_wdata[`IRQ_BITS-1:0] : irq_enable;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      irq_status <= `RST_IRQ;
      irq_enable <= `RST_IRQ;
      o_irq      <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (wr_en) begin
        irq_enable <= i_wdata[`IRQ_BITS-1:0];
      end
      // Built from next values so the flop follows status with no lag
      o_irq <= |(next_status & next_enable);
    end
  end

  // Read data, valid only in the cycle after the strobe
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_addr)
      `OFS_TX_STATE_FOUR: begin
        rd_mux[`F_TAG_HI:`F_TAG_LO]         = packet_tag_byte;
        rd_mux[`F_BUF_LAST]                 = buf_is_last;
        rd_mux[`F_BUF_FIRST]                = buf_is_first;
        rd_mux[`F_BUF_LEFT_HI:`F_BUF_LEFT_LO] = buf_bytes_left;
      end
      `OFS_TX_STATE_FIVE: begin
        rd_mux[`F_CUT_HI:`F_CUT_LO]         = bytes_until_cut;
        rd_mux[`F_PKT_LEN_HI:`F_PKT_LEN_LO] = pkt_len;
      end
      `OFS_TX_DONE_PTR: begin
        // Mode select and bit 1 always read as zero
        rd_mux[`F_PTR_HI:`F_PTR_LO]         = done_desc_ptr;
      end
      `OFS_RX_STATE_ZERO: begin
        rd_mux[`F_SKIP_HI:`F_SKIP_LO]       = first_buf_skip;
      end
      `OFS_IRQ_STATUS: begin
        rd_mux[`IRQ_BITS-1:0]               = irq_status;
      end
      `OFS_IRQ_ENABLE: begin
        rd_mux[`IRQ_BITS-1:0]               = irq_enable;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= `RST_WORD;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= `RST_WORD;
    end
  end

endmodule

`default_nettype wire

// File: testbench/pkt_dma_chan_sva.sv
/* Checker for the packet DMA channel state block.
   Assumes it sees only the top module ports, bound below. */
`timescale 1ns/1ps
`default_nettype none
module pkt_dma_chan_sva #(
  parameter AW = 8,
  parameter LW = 16
) (
  input wire logic          i_mclk,
  input wire logic          i_rst,
  input wire logic [AW-1:0] i_addr,
  input wire logic [31:0]   i_wdata,
  input wire logic          i_wr,
  input wire logic          i_rd,
  input wire logic [31:0]   o_rdata,
  input wire logic          i_sop_load,
  input wire logic [7:0]    i_sop_tag,
  input wire logic [LW-1:0] i_sop_pkt_len,
  input wire logic          i_xfer,
  input wire logic          i_eop_done,
  input wire logic          i_rx_sop_start,
  input wire logic          i_rx_byte,
  input wire logic [7:0]    i_rx_data,
  input wire logic          o_next_desc,
  input wire logic          o_pkt_cut,
  input wire logic [LW-1:0] o_trailer_len,
  input wire logic [7:0]    o_rx_tag,
  input wire logic          o_rx_store,
  input wire logic [7:0]    o_rx_store_data,
  input wire logic          o_txq_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire ptr_wr = i_wr && i_addr == 8'h08;
  a_tag_carried: assert property (i_sop_load |-> ##2 o_rx_tag == $past(i_sop_tag, 2))
    else $error("tag byte not carried");
  a_len_trailer: assert property (i_sop_load |-> ##2 o_trailer_len == $past(i_sop_pkt_len, 2))
    else $error("trailer length wrong");
  a_wb_raises: assert property (ptr_wr && i_wdata[0] |=> o_txq_irq)
    else $error("writeback did not raise queue irq");
  a_eop_raises: assert property (i_eop_done |=> o_txq_irq)
    else $error("end of packet did not raise queue irq");
  a_cmp_no_raise: assert property (ptr_wr && !i_wdata[0] && !i_eop_done && !o_txq_irq |=> !o_txq_irq)
    else $error("compare write raised queue irq");
  a_sel_zero: assert property (i_rd && i_addr == 8'h08 |=> o_rdata[1:0] == 2'b00)
    else $error("mode bit read nonzero");
  a_next_cause: assert property (o_next_desc |-> $past(i_xfer, 2))
    else $error("next descriptor without transfer");
  a_cut_cause: assert property (o_pkt_cut |-> $past(i_xfer, 2))
    else $error("cut pulse without transfer");
  a_sop_skip: assert property (i_rx_sop_start && !i_rx_byte |=> !o_rx_store)
    else $error("byte stored at first buffer start");
  a_store_data: assert property (o_rx_store |-> $past(i_rx_byte) && o_rx_store_data == $past(i_rx_data))
    else $error("stored byte mismatch");
  c_next: cover property (o_next_desc);
  c_cut: cover property (o_pkt_cut);
  c_store: cover property (o_rx_store);
endmodule
bind pkt_dma_chan_state pkt_dma_chan_sva #(.AW(AW), .LW(LW)) chk (.*);
`default_nettype wire

// File: testbench/pkt_dma_chan_state_test.sv
/* Testbench for the packet DMA channel state block.
   Assumes the register header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "pkt_dma_regs.vh"
module pkt_dma_chan_state_test;
  logic        i_mclk, i_rst, i_wr, i_rd, i_sop_load, i_buf_load, i_buf_first, i_buf_last;
  logic        i_xfer, i_eop_done, i_rx_sop_start, i_rx_byte;
  logic        o_next_desc, o_pkt_cut, o_rx_store, o_txq_irq, o_irq;
  logic [7:0]  i_addr, i_sop_tag, i_rx_data, o_rx_tag, o_rx_store_data;
  logic [31:0] i_wdata, o_rdata;
  logic [15:0] i_sop_pkt_len, i_buf_len, i_xfer_bytes, o_trailer_len;
  logic [29:0] i_eop_done_desc_ptr;
  int          err_total, num_checks, cyc;
  logic [7:0]  rxq[$];
  pkt_dma_chan_state dut (.*);
  initial begin
    i_mclk = 0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (o_rx_store) rxq.push_back(o_rx_store_data);
    cyc++;
    // Whole run needs well under this
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic step(int n = 1); repeat (n) @(posedge i_mclk); endtask
  task automatic cmp(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    step(); i_wr <= 1; i_addr <= a; i_wdata <= d;
    step(); i_wr <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    step(); i_rd <= 1; i_addr <= a;
    step(); i_rd <= 0;
    #1 cmp("rdata", e, o_rdata);
  endtask
  // Pulses land two edges after the emptying transfer
  task automatic xfer(logic [15:0] n, logic [1:0] e);
    logic [1:0] seen = 0;
    step(); i_xfer <= 1; i_xfer_bytes <= n;
    step(); i_xfer <= 0;
    repeat (4) begin step(); #1 seen |= {o_next_desc, o_pkt_cut}; end
    cmp("pulses", e, seen);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 32; a += 4) rd(a[7:0], 0);
    wr(`OFS_TX_STATE_FOUR, 32'hFFFF_FFFF);
    rd(`OFS_TX_STATE_FOUR, 32'hFF03_FFFF);
    wr(`OFS_TX_STATE_FIVE, 32'h1234_5678);
    rd(`OFS_TX_STATE_FIVE, 32'h1234_5678);
    wr(`OFS_RX_STATE_ZERO, 32'hFFFF_FFFF);
    rd(`OFS_RX_STATE_ZERO, 32'h0000_00FF);
    wr(`OFS_TX_DONE_PTR, 32'hFFFF_FFFF);
    #1 cmp("txq_irq", 1, o_txq_irq);
    rd(`OFS_TX_DONE_PTR, 32'hFFFF_FFFC);
    wr(`OFS_TX_DONE_PTR, 32'h0000_0004);
    #1 cmp("txq_irq", 1, o_txq_irq);
    wr(`OFS_TX_DONE_PTR, 32'hFFFF_FFFC);
    #1 cmp("txq_irq", 0, o_txq_irq);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0007);
  endtask
  task automatic t_tx();
    step(); i_sop_load <= 1; i_sop_tag <= 8'h5A; i_sop_pkt_len <= 16'h0006;
    i_buf_load <= 1; i_buf_len <= 16'h0004; i_buf_first <= 1; i_buf_last <= 0;
    step(); i_sop_load <= 0; i_buf_load <= 0;
    step();
    #1 cmp("rx_tag", 8'h5A, o_rx_tag);
    cmp("trailer", 16'h0006, o_trailer_len);
    rd(`OFS_TX_STATE_FOUR, 32'h5A01_0004);
    rd(`OFS_TX_STATE_FIVE, 32'h0006_0006);
    xfer(16'h0003, 2'b00);
    rd(`OFS_TX_STATE_FOUR, 32'h5A01_0001);
    rd(`OFS_TX_STATE_FIVE, 32'h0003_0006);
    xfer(16'h0001, 2'b10);
    step(); i_buf_load <= 1; i_buf_len <= 16'h0002; i_buf_first <= 0; i_buf_last <= 1;
    step(); i_buf_load <= 0;
    rd(`OFS_TX_STATE_FOUR, 32'h5A02_0002);
    xfer(16'h0002, 2'b11);
    rd(`OFS_IRQ_STATUS, 32'h0000_0006);
    rd(`OFS_TX_STATE_FIVE, 32'h0000_0006);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0007);
    rd(`OFS_IRQ_STATUS, 32'h0000_0000);
  endtask
  task automatic t_irq();
    wr(`OFS_IRQ_ENABLE, 32'h0000_0001);
    step(); i_eop_done <= 1; i_eop_done_desc_ptr <= 30'h0ABC_DEF1;
    step(); i_eop_done <= 0;
    #1 cmp("txq_irq", 1, o_txq_irq);
    cmp("irq", 1, o_irq);
    step();
    #1 cmp("irq", 1, o_irq);
    rd(`OFS_TX_DONE_PTR, {30'h0ABC_DEF1, 2'b00});
    rd(`OFS_IRQ_STATUS, 32'h0000_0001);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0000);
    #1 cmp("irq", 0, o_irq);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0001);
    rd(`OFS_IRQ_STATUS, 32'h0000_0000);
    wr(`OFS_TX_DONE_PTR, {30'h0ABC_DEF1, 2'b00});
    #1 cmp("txq_irq", 0, o_txq_irq);
    // Compare write while the queue interrupt is already low
    wr(`OFS_TX_DONE_PTR, 32'h0000_0010);
    #1 cmp("txq_irq", 0, o_txq_irq);
  endtask
  task automatic t_rx();
    rxq.delete();
    wr(`OFS_RX_STATE_ZERO, 32'h0000_0002);
    step(); i_rx_sop_start <= 1;
    step(); i_rx_sop_start <= 0; i_rx_byte <= 1;
    for (int k = 1; k <= 4; k++) begin
      i_rx_data <= 8'h11 * k;
      step();
    end
    i_rx_byte <= 0;
    step(2);
    cmp("stored", 2, rxq.size());
    cmp("byte0", 8'h33, rxq[0]);
    cmp("byte1", 8'h44, rxq[1]);
    // A byte that comes with the strobe is the buffer's first byte
    for (int s = 0; s < 2; s++) begin
      rxq.delete();
      wr(`OFS_RX_STATE_ZERO, s);
      step(); i_rx_sop_start <= 1; i_rx_byte <= 1; i_rx_data <= 8'h55;
      step(); i_rx_sop_start <= 0; i_rx_data <= 8'h66;
      step(); i_rx_byte <= 0;
      step(2);
      cmp("stored", 2 - s, rxq.size());
      cmp("first", s ? 8'h66 : 8'h55, rxq[0]);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {i_rst, i_wr, i_rd, i_sop_load, i_buf_load, i_buf_first, i_buf_last} = 7'h01 << 6;
    {i_xfer, i_eop_done, i_rx_sop_start, i_rx_byte} = 4'h0;
    {i_addr, i_sop_tag, i_rx_data, i_wdata} = 56'h0;
    {i_sop_pkt_len, i_buf_len, i_xfer_bytes, i_eop_done_desc_ptr} = 78'h0;
    step(4);
    i_rst <= 0;
    t_regs();
    t_tx();
    t_irq();
    t_rx();
    finish_test();
  end
endmodule
`default_nettype wire
